// ---- hdl/osc_select_control.sv ----
// How it works
// (RULE1) Answers peripheral 4 only; every register access is one byte.
// (RULE2) Control bit 0 picks source: 0 crystal, 1 internal; reset from strap.
// (RULE3) With control bit 1 set, a source change resets the tile; resets 0.
// (RULE4) Internal bit 1 picks speed: 0 fast near 20 MHz, 1 slow; resets 0.
// (RULE5) Internal bit 0 resets to 1; writing 0 stops the internal oscillator.
// (RULE6) Software stops internal oscillator only while tile runs on crystal.
// (RULE7) Crystal bit 1 resets to 1; writing 0 turns bias circuit off.
// (RULE8) Software disables bias only with an external oscillator attached.
// (RULE9) Crystal bit 0 resets to 1; writing 0 stops the crystal oscillator.
// (RULE10) Software stops crystal only while tile runs on internal oscillator.
// (RULE11) Bits 7:2 of all three registers are reserved, read zero.
// (RULE12) Source switch is break-before-make so no short pulse reaches tile; strap load after reset moves select with no hold.
`timescale 1ns/1ps
`default_nettype none
module osc_select_control
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic strapSelect,
   input wire osc_pkg::osc_req_t busReq,
   output osc_pkg::osc_rsp_t busRsp,
   output logic clkSelect,
   output logic muxHoldOff,
   output logic tileReset,
   output logic intOscEnable,
   output logic intOscSlow,
   output logic xtalEnable,
   output logic xtalBiasEnable
);
   import osc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic hit(input osc_req_t r, input logic [7:0] a);
      hit = r.req && (r.periph == PERIPH_ID) && (r.addr == a);
   endfunction : hit

   logic selReg_r, selReg_nxt, rstEn_r, rstEn_nxt;
   logic intEn_r, intEn_nxt, intSlow_r, intSlow_nxt;
   logic xtalEn_r, xtalEn_nxt, xtalBias_r, xtalBias_nxt;
   logic strapDone_r, strapDone_nxt;
   osc_rsp_t rsp_r, rsp_nxt;

   always_comb
   begin
      selReg_nxt = selReg_r;
      rstEn_nxt = rstEn_r;
      intEn_nxt = intEn_r;
      intSlow_nxt = intSlow_r;
      xtalEn_nxt = xtalEn_r;
      xtalBias_nxt = xtalBias_r;
      strapDone_nxt = 1'b1;
      rsp_nxt = '0;
      // Strap sampled on first edge after release, async reset stays constant
      if (!strapDone_r)
         selReg_nxt = strapSelect; // see (RULE2)
      if (busReq.req && busReq.periph == PERIPH_ID) // see (RULE1)
         rsp_nxt.ack = 1'b1;
      if (busReq.write)
      begin
         // Only bits 1:0 stored; upper bits dropped, see (RULE11)
         if (hit(busReq, CLOCK_SOURCE_CONTROL))
         begin
            selReg_nxt = busReq.wdata[SEL_BIT]; // see (RULE2)
            rstEn_nxt = busReq.wdata[RSTEN_BIT]; // see (RULE3)
         end
         if (hit(busReq, INTERNAL_OSCILLATOR_CONTROL))
         begin
            intEn_nxt = busReq.wdata[INT_EN_BIT]; // see (RULE5)
            intSlow_nxt = busReq.wdata[INT_SLOW_BIT]; // see (RULE4)
         end
         if (hit(busReq, CRYSTAL_OSCILLATOR_CONTROL))
         begin
            xtalEn_nxt = busReq.wdata[XTAL_EN_BIT]; // see (RULE9)
            xtalBias_nxt = busReq.wdata[XTAL_BIAS_BIT]; // see (RULE7)
         end
      end
      else
      begin
         if (hit(busReq, CLOCK_SOURCE_CONTROL))
            rsp_nxt.rdata = {6'h00, rstEn_r, selReg_r}; // see (RULE11)
         if (hit(busReq, INTERNAL_OSCILLATOR_CONTROL))
            rsp_nxt.rdata = {6'h00, intSlow_r, intEn_r};
         if (hit(busReq, CRYSTAL_OSCILLATOR_CONTROL))
            rsp_nxt.rdata = {6'h00, xtalBias_r, xtalEn_r};
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         selReg_r <= 1'b0;
         rstEn_r <= RSTEN_RESET;
         intEn_r <= INT_EN_RESET;
         intSlow_r <= INT_SLOW_RESET;
         xtalEn_r <= XTAL_EN_RESET;
         xtalBias_r <= XTAL_BIAS_RESET;
         strapDone_r <= 1'b0;
         rsp_r <= '0;
      end
      else
      begin
         selReg_r <= selReg_nxt;
         rstEn_r <= rstEn_nxt;
         intEn_r <= intEn_nxt;
         intSlow_r <= intSlow_nxt;
         xtalEn_r <= xtalEn_nxt;
         xtalBias_r <= xtalBias_nxt;
         strapDone_r <= strapDone_nxt;
         rsp_r <= rsp_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Switch sequencer: hold mux off, flip select, settle, release
   osc_sw_t swState_r, swState_nxt;
   logic [4:0] swCnt_r, swCnt_nxt;
   logic clkSel_r, clkSel_nxt, holdOff_r, holdOff_nxt;
   logic tileRst_r, tileRst_nxt;
   logic [4:0] rstCnt_r, rstCnt_nxt;

   always_comb
   begin
      swState_nxt = swState_r;
      swCnt_nxt = swCnt_r;
      clkSel_nxt = clkSel_r;
      holdOff_nxt = holdOff_r;
      rstCnt_nxt = rstCnt_r;
      tileRst_nxt = (rstCnt_r != 5'h00);
      if (rstCnt_r != 5'h00)
         rstCnt_nxt = rstCnt_r - 5'h01;
      unique case (swState_r)
         SW_IDLE:
            if (strapDone_r && selReg_r != clkSel_r)
            begin
               // Gate tile clock before the source moves, see (RULE12)
               holdOff_nxt = 1'b1;
               swCnt_nxt = 5'(SWITCH_SETTLE_CYCLES);
               swState_nxt = SW_STOP;
               if (rstEn_r) // see (RULE3)
                  rstCnt_nxt = 5'(TILE_RST_CYCLES);
            end
         SW_STOP:
            if (swCnt_r == 5'h00)
            begin
               clkSel_nxt = selReg_r;
               swCnt_nxt = 5'(SWITCH_SETTLE_CYCLES);
               swState_nxt = SW_SETTLE;
            end
            else
               swCnt_nxt = swCnt_r - 5'h01;
         SW_SETTLE:
            if (swCnt_r == 5'h00)
            begin
               holdOff_nxt = 1'b0; // see (RULE12)
               swState_nxt = SW_IDLE;
            end
            else
               swCnt_nxt = swCnt_r - 5'h01;
         default:
            swState_nxt = SW_IDLE;
      endcase
      // Before strap capture the output simply follows the strap
      if (!strapDone_r)
         clkSel_nxt = strapSelect;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         swState_r <= SW_IDLE;
         swCnt_r <= 5'h00;
         clkSel_r <= 1'b0;
         holdOff_r <= 1'b0;
         tileRst_r <= 1'b0;
         rstCnt_r <= 5'h00;
      end
      else
      begin
         swState_r <= swState_nxt;
         swCnt_r <= swCnt_nxt;
         clkSel_r <= clkSel_nxt;
         holdOff_r <= holdOff_nxt;
         tileRst_r <= tileRst_nxt;
         rstCnt_r <= rstCnt_nxt;
      end
   end

   assign busRsp = rsp_r;
   assign clkSelect = clkSel_r;
   assign muxHoldOff = holdOff_r;
   assign tileReset = tileRst_r;
   assign intOscEnable = intEn_r;
   assign intOscSlow = intSlow_r;
   assign xtalEnable = xtalEn_r;
   assign xtalBiasEnable = xtalBias_r;

   ////////////////////////////////////////////////////////////////////////////
   a_sel_hold: assert property (@(posedge clock) // see (RULE12)
      disable iff (!rst_n)
      (swState_r == SW_IDLE && $changed(clkSel_r) && strapDone_r
         && $past(strapDone_r)) |-> 1'b0)
      else $error("select moved outside a held switch");
   a_hold_cover: assert property (@(posedge clock) // see (RULE12)
      disable iff (!rst_n)
      $changed(clkSel_r) && $past(strapDone_r, 2)
      |-> holdOff_r && $past(holdOff_r))
      else $error("select moved without hold off");
   a_tile_reset: assert property (@(posedge clock) // see (RULE3)
      disable iff (!rst_n)
      (swState_r == SW_IDLE && strapDone_r && selReg_r != clkSel_r && rstEn_r)
      |-> ##2 tileRst_r [*8])
      else $error("tile reset missing on source change");
   a_no_reset: assert property (@(posedge clock) // see (RULE3)
      disable iff (!rst_n)
      (rstCnt_r == 5'h00 && !(swState_r == SW_IDLE && selReg_r != clkSel_r
         && rstEn_r)) |=> ##1 !tileRst_r)
      else $error("tile reset without cause");
   a_ack_one: assert property (@(posedge clock) // see (RULE1)
      disable iff (!rst_n)
      busReq.req && busReq.periph == PERIPH_ID |=> busRsp.ack)
      else $error("access not acknowledged");
   a_ack_other: assert property (@(posedge clock) // see (RULE1)
      disable iff (!rst_n)
      !(busReq.req && busReq.periph == PERIPH_ID) |=> !busRsp.ack)
      else $error("foreign access acknowledged");
   a_rsvd_zero: assert property (@(posedge clock) // see (RULE11)
      disable iff (!rst_n)
      busRsp.rdata[7:2] == 6'h00)
      else $error("reserved bits not zero");
   a_int_write: assert property (@(posedge clock) // see (RULE5) (RULE4)
      disable iff (!rst_n)
      busReq.write && hit(busReq, INTERNAL_OSCILLATOR_CONTROL)
      |=> intOscEnable == $past(busReq.wdata[INT_EN_BIT])
         && intOscSlow == $past(busReq.wdata[INT_SLOW_BIT]))
      else $error("internal oscillator write lost");
   a_xtal_write: assert property (@(posedge clock) // see (RULE9) (RULE7)
      disable iff (!rst_n)
      busReq.write && hit(busReq, CRYSTAL_OSCILLATOR_CONTROL)
      |=> xtalEnable == $past(busReq.wdata[XTAL_EN_BIT])
         && xtalBiasEnable == $past(busReq.wdata[XTAL_BIAS_BIT]))
      else $error("crystal write lost");
endmodule : osc_select_control
`default_nettype wire

// ---- hdl/osc_pkg.sv ----
`default_nettype none
package osc_pkg;
   // Peripheral access port identity and byte register offsets
   localparam logic [7:0] PERIPH_ID = 8'h04;
   localparam logic [7:0] CLOCK_SOURCE_CONTROL = 8'h00;
   localparam logic [7:0] INTERNAL_OSCILLATOR_CONTROL = 8'h01;
   localparam logic [7:0] CRYSTAL_OSCILLATOR_CONTROL = 8'h02;
   // Field positions
   localparam int SEL_BIT = 0;
   localparam int RSTEN_BIT = 1;
   localparam int INT_EN_BIT = 0;
   localparam int INT_SLOW_BIT = 1;
   localparam int XTAL_EN_BIT = 0;
   localparam int XTAL_BIAS_BIT = 1;
   // Reset values
   localparam logic RSTEN_RESET = 1'b0;
   localparam logic INT_EN_RESET = 1'b1;
   localparam logic INT_SLOW_RESET = 1'b0;
   localparam logic XTAL_EN_RESET = 1'b1;
   localparam logic XTAL_BIAS_RESET = 1'b1;
   // Tile reset pulse length and switch settle time
   localparam int TILE_RST_CYCLES = 16;
   localparam int SWITCH_SETTLE_CYCLES = 4;

   typedef struct packed {
      logic req;
      logic write;
      logic [7:0] periph;
      logic [7:0] addr;
      logic [7:0] wdata;
   } osc_req_t;

   typedef struct packed {
      logic ack;
      logic [7:0] rdata;
   } osc_rsp_t;

   typedef enum logic [1:0] {
      SW_IDLE = 2'b00,
      SW_STOP = 2'b01,
      SW_SETTLE = 2'b10
   } osc_sw_t;
endpackage : osc_pkg
`default_nettype wire

// ---- test/tb_osc_select_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_osc_select_control;
   import osc_pkg::*;
   logic clock;
   logic rst_n;
   logic strapSelect;
   osc_req_t busReq;
   osc_rsp_t busRsp;
   logic clkSelect, muxHoldOff, tileReset;
   logic intOscEnable, intOscSlow, xtalEnable, xtalBiasEnable;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   logic [7:0] rd;
   logic ok;
   osc_select_control uut (.clock(clock), .rst_n(rst_n),
      .strapSelect(strapSelect), .busReq(busReq), .busRsp(busRsp),
      .clkSelect(clkSelect), .muxHoldOff(muxHoldOff),
      .tileReset(tileReset), .intOscEnable(intOscEnable),
      .intOscSlow(intOscSlow), .xtalEnable(xtalEnable),
      .xtalBiasEnable(xtalBiasEnable));
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // Whole run is well under this; a stuck handshake lands here
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task conclude;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude
   task doReset(input logic strap);
      @(negedge clock);
      rst_n = 1'b0;
      strapSelect = strap;
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
   endtask : doReset
   // Request held through the taking edge; ack looked for over two cycles
   task access(input logic wr, input logic [7:0] per, input logic [7:0] ad,
      input logic [7:0] wd);
      @(negedge clock);
      busReq = '{1'b1, wr, per, ad, wd};
      @(posedge clock);
      @(negedge clock);
      busReq.req = 1'b0;
      ok = 1'b0;
      rd = 8'h00;
      for (int i = 0; i < 2 && !ok; i++)
      begin
         if (busRsp.ack === 1'b1)
         begin
            ok = 1'b1;
            rd = busRsp.rdata;
         end
         else
            @(negedge clock);
      end
   endtask : access
   function automatic logic [7:0] outs();
      return {4'h0, intOscEnable, intOscSlow, xtalEnable, xtalBiasEnable};
   endfunction : outs
   task writeBack(input logic [7:0] ad, input logic [7:0] wd,
      input logic [7:0] expRd, input logic [7:0] expOuts);
      access(1'b1, 8'h04, ad, wd);
      access(1'b0, 8'h04, ad, 8'h00);
      check(rd, expRd);
      check(outs(), expOuts);
   endtask : writeBack
   ////////////////////////////////////////////////////////////////////////
   task testResetValues;
      access(1'b0, 8'h04, 8'h00, 8'h00);
      check(rd, 8'h00);
      access(1'b0, 8'h04, 8'h01, 8'h00);
      check(rd, 8'h01);
      access(1'b0, 8'h04, 8'h02, 8'h00);
      check(rd, 8'h03);
      check({5'h0, clkSelect, muxHoldOff, tileReset}, 8'h00);
   endtask : testResetValues
   // Each oscillator is stopped only while the tile runs on the other one
   task testFields;
      writeBack(8'h01, 8'hFE, 8'h02, 8'h07);
      writeBack(8'h01, 8'hFD, 8'h01, 8'h0B);
      access(1'b1, 8'h04, 8'h00, 8'h01);
      repeat (20) @(negedge clock);
      check({7'h0, clkSelect}, 8'h01);
      writeBack(8'h02, 8'hFE, 8'h02, 8'h09);
      // Bias off stands for an external oscillator on the crystal pins
      writeBack(8'h02, 8'hFD, 8'h01, 8'h0A);
      writeBack(8'h02, 8'hFF, 8'h03, 8'h0B);
      access(1'b1, 8'h04, 8'h00, 8'h00);
      repeat (20) @(negedge clock);
      check({6'h0, clkSelect, tileReset}, 8'h00);
   endtask : testFields
   // Other peripheral numbers must be invisible to this block
   task testPeriph;
      access(1'b1, 8'h03, 8'h01, 8'h00);
      check({7'h0, ok}, 8'h00);
      access(1'b1, 8'h05, 8'h02, 8'h00);
      check(outs(), 8'h0B);
      access(1'b0, 8'h04, 8'h03, 8'h00);
      check({7'h0, ok}, 8'h01);
      check(rd, 8'h00);
   endtask : testPeriph
   task testSwitch(input logic [7:0] wd, input int expRst, input logic sel);
      int rstCount;
      logic prev;
      rstCount = 0;
      access(1'b1, 8'h04, 8'h00, wd);
      prev = clkSelect;
      repeat (40)
      begin
         @(negedge clock);
         if (tileReset === 1'b1)
            rstCount++;
         if (clkSelect !== prev)
            check({7'h0, muxHoldOff}, 8'h01);
         prev = clkSelect;
      end
      check(8'(rstCount), 8'(expRst));
      check({6'h0, clkSelect, muxHoldOff}, {6'h0, sel, 1'b0});
   endtask : testSwitch
   task testStrap;
      doReset(1'b1);
      access(1'b0, 8'h04, 8'h00, 8'h00);
      check(rd, 8'h01);
      check({7'h0, clkSelect}, 8'h01);
   endtask : testStrap
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_n = 1'b0;
      strapSelect = 1'b0;
      busReq = '0;
      doReset(1'b0);
      testResetValues();
      testFields();
      testPeriph();
      testSwitch(8'h03, TILE_RST_CYCLES, 1'b1);
      testSwitch(8'h02, TILE_RST_CYCLES, 1'b0);
      testSwitch(8'h01, 0, 1'b1);
      testSwitch(8'h00, 0, 1'b0);
      testStrap();
      conclude();
   end
endmodule : tb_osc_select_control
`default_nettype wire
